// ### hw/mrl_defines.svh
`ifndef MRL_DEFINES_SVH
`define MRL_DEFINES_SVH
// Functional notes
// - Read commands are ignored until an access code arrives since reset or exit.
// - Target field is one-hot per die; bit 0 selects die 0.
// - Response line is only pulled low; external pull-up gives high level.
// - Response: sync 00, die ID, four flags, 16 data bits, 3-bit CRC.
// - Die ID in the response is binary coded, 00 to 11.
// - Broadcast flag is one when the read had an all-zero target field.
// - Wrong bit lengths discard the frame and latch abort flag until next response.
// - A command completed during a response latches overrun until next response.
// - A command failing CRC latches checksum flag until next response.
// - Even address returns even byte in 15:8 and odd byte in 7:0.
// - Odd address returns odd byte in 7:0 with upper byte zero.
// - Response starts within a quarter bit of the command's last bit end.
// - CRC covers all bits after the two sync bits and ends each frame.
// - CRC x^3+x+1, preset 111, MSB first, sent C2 C1 C0.
// - At power-up nonvolatile words are copied into shadow registers used for operation.
// - Extended writes may overwrite shadow registers without touching nonvolatile copy.
// - Shadow registers sit 0x40 above their nonvolatile words, same layout.
// - Bits unused in the nonvolatile word are absent in shadow and read 0.
// - Shadow registers keep data bits only, no correction check bits.
// - Shadow writes obey the same lock restrictions as nonvolatile writes.
// - All shadow and nonvolatile registers are readable without unlocking; extended reads below 0x40 return 0.
// - Access code: write, any target, address 111111, data 0x62D2; enters mode.
// - Write to address 111111 with other data exits the mode on every die.

`define MRL_CRC_PRESET 3'h7
`define MRL_READ_LEN 5'h0E
`define MRL_WRITE_LEN 5'h1E
`define MRL_CRC_LEN 5'h03
`define MRL_RESP_LEN 5'h1B
`define MRL_RESP_PAYLOAD 22
`define MRL_MODE_ADDR 6'h3F
`define MRL_ACCESS_DATA 16'h62D2
`define MRL_SHADOW_OFS 8'h40
`define MRL_LOCK_ALL 4'h3
`define MRL_MIN_PERIOD 16'h000C
`endif

// ### hw/mrl_pkg.sv
package mrl_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_SYNC, RX_BITS} rx_state_e;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_SEND} tx_state_e;
  typedef enum logic [1:0] {SH_LOAD, SH_READY, SH_WRITE} sh_state_e;

  // Decoded command fields
  typedef struct packed {
    logic rw;
    logic [3:0] target;
    logic [5:0] addr;
    logic [15:0] data;
  } cmd_s;

  // Return status of one response
  typedef struct packed {
    logic [1:0] die_id;
    logic broadcast_flag;
    logic abort_error_flag;
    logic overrun_flag;
    logic checksum_flag;
  } status_s;

  // Extended access request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } ext_req_s;

  // Nonvolatile word as delivered by the array
  typedef struct packed {
    logic [6:0] ecc;
    logic [31:0] used;
    logic [31:0] data;
  } nv_word_s;
endpackage

// ### hw/mrl_shadow_ram.sv
`timescale 1ns/1ps
module mrl_shadow_ram #(
  parameter int AW = 6,
  parameter int DW = 64
) (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [DW-1:0] o_rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Write port and registered read port
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

// ### hw/mrl_link.sv
`timescale 1ns/1ps
`include "mrl_defines.svh"
module mrl_link import mrl_pkg::*; #(
  parameter int CW = 16,
  parameter int DEPTH = 64
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_cmd_line,
  input wire logic [1:0] i_die_sel,
  output logic o_link_out,
  output logic o_link_oe,
  output logic o_manch_on,
  output logic o_reg_rd,
  output logic [5:0] o_reg_addr,
  input wire logic [15:0] i_reg_word,
  output logic [5:0] o_nv_addr,
  input wire nv_word_s i_nv_word,
  output logic o_shadow_ready,
  input wire logic [3:0] i_lock_field,
  input wire logic i_ext_wr,
  input wire logic i_ext_rd,
  input wire ext_req_s i_ext_req,
  output logic o_ext_busy,
  output logic o_ext_wdone,
  output logic o_ext_werr,
  output logic o_ext_rvalid,
  output logic [31:0] o_ext_rdata
);
  localparam int AW = $clog2(DEPTH);

  // One CRC step, MSB-first input
  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
    logic c0;
    c0 = c[2] ^ b;
    crc_step = {c[1], c0 ^ c[0], c0};
  endfunction

  // CRC over a full response payload
  function automatic logic [2:0] crc_payload(input logic [`MRL_RESP_PAYLOAD-1:0] p);
    logic [2:0] c;
    c = `MRL_CRC_PRESET;
    for (int i = `MRL_RESP_PAYLOAD - 1; i >= 0; i--) begin
      c = crc_step(c, p[i]);
    end
    crc_payload = c;
  endfunction

  // ---------------- Receiver ----------------
  rx_state_e rx_state, next_rx_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [CW-1:0] period, next_period;
  logic [CW-1:0] qtr, next_qtr;
  logic h1, next_h1;
  logic [4:0] nbits, next_nbits;
  logic [29:0] shift, next_shift;
  logic [2:0] crc, next_crc;
  logic line_q;
  logic rx_done, rx_ok, rx_abort;
  cmd_s rx_cmd;

  // Bit recovery, length and CRC check
  always_comb begin
    logic [4:0] len;
    logic bit_v;
    len = 5'h00;
    bit_v = i_cmd_line;
    next_rx_state = rx_state;
    next_cnt = cnt;
    next_period = period;
    next_qtr = qtr;
    next_h1 = h1;
    next_nbits = nbits;
    next_shift = shift;
    next_crc = crc;
    rx_done = 1'b0;
    rx_ok = 1'b0;
    rx_abort = 1'b0;
    rx_cmd = '0;
    unique case (rx_state)
      RX_IDLE: begin
        if (line_q && !i_cmd_line) begin
          next_rx_state = RX_SYNC;
          next_cnt = '0;
        end
      end
      RX_SYNC: begin
        next_cnt = cnt + 1'b1;
        if (line_q && !i_cmd_line) begin
          if (cnt + 1'b1 >= `MRL_MIN_PERIOD) begin
            next_period = cnt + 1'b1;
            next_qtr = (cnt + 1'b1) >> 2;
            next_rx_state = RX_BITS;
          end else begin
            next_rx_state = RX_IDLE;
          end
          next_cnt = '0;
          next_nbits = '0;
          next_shift = '0;
          next_crc = `MRL_CRC_PRESET;
        end else if (&cnt) begin
          next_rx_state = RX_IDLE;
        end
      end
      RX_BITS: begin
        next_cnt = cnt + 1'b1;
        if (cnt == period - qtr) begin
          next_h1 = i_cmd_line;
        end
        if (cnt == period + qtr) begin
          next_cnt = qtr + 1'b1;
          // Frame length from the read/write bit, now nbits-1 places up the shifter
          len = ((nbits == 5'h00) ? bit_v : shift[nbits - 5'h01]) ? `MRL_READ_LEN : `MRL_WRITE_LEN;
          if (h1 == bit_v) begin
            rx_abort = 1'b1;
            next_rx_state = RX_IDLE;
          end else begin
            next_shift = {shift[28:0], bit_v};
            next_nbits = nbits + 1'b1;
            // sync excluded, CRC bits not fed
            if (nbits < len - `MRL_CRC_LEN) begin
              next_crc = crc_step(crc, bit_v);
            end
            if (nbits + 1'b1 == len) begin
              rx_done = 1'b1;
              next_rx_state = RX_IDLE;
              if (len == `MRL_READ_LEN) begin
                rx_cmd = {next_shift[13:3], 16'h0000};
              end else begin
                rx_cmd = next_shift[29:3];
              end
              rx_ok = (crc == next_shift[2:0]);
            end
          end
        end
      end
      default: next_rx_state = RX_IDLE;
    endcase
  end

  // Receiver registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rx_state <= RX_IDLE;
      cnt <= '0;
      period <= '0;
      qtr <= '0;
      h1 <= 1'b0;
      nbits <= '0;
      shift <= '0;
      crc <= `MRL_CRC_PRESET;
      line_q <= 1'b1;
    end else begin
      rx_state <= next_rx_state;
      cnt <= next_cnt;
      period <= next_period;
      qtr <= next_qtr;
      h1 <= next_h1;
      nbits <= next_nbits;
      shift <= next_shift;
      crc <= next_crc;
      line_q <= i_cmd_line;
    end
  end

  // ---------------- Mode and flags ----------------
  tx_state_e tx_state, next_tx_state;
  logic manch_on, next_manch_on;
  logic ae, next_ae, ovr, next_ovr, cs, next_cs;
  logic tx_load, accept, tx_busy, target_hit;

  assign tx_busy = (tx_state != TX_IDLE);
  // one-hot target, zero means all dies
  assign target_hit = (rx_cmd.target == 4'h0) || rx_cmd.target[i_die_sel];
  assign accept = rx_done && rx_ok && manch_on && rx_cmd.rw && !tx_busy && target_hit;

  // Sticky flags: set wins over clear at load
  always_comb begin
    next_manch_on = manch_on;
    if (rx_done && rx_ok && !rx_cmd.rw && rx_cmd.addr == `MRL_MODE_ADDR) begin
      next_manch_on = (rx_cmd.data == `MRL_ACCESS_DATA);
    end
    next_ae = (ae && !tx_load) || (rx_abort && manch_on);
    next_ovr = (ovr && !tx_load) || (rx_done && rx_ok && manch_on && tx_busy);
    next_cs = (cs && !tx_load) || (rx_done && !rx_ok && manch_on);
  end

  // Mode and flag registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      manch_on <= 1'b0;
      ae <= 1'b0;
      ovr <= 1'b0;
      cs <= 1'b0;
      o_manch_on <= 1'b0;
    end else begin
      manch_on <= next_manch_on;
      ae <= next_ae;
      ovr <= next_ovr;
      cs <= next_cs;
      o_manch_on <= next_manch_on;
    end
  end

  // ---------------- Transmitter ----------------
  logic [26:0] tx_shift, next_tx_shift;
  logic [4:0] tx_left, next_tx_left;
  logic tx_half, next_tx_half;
  logic [CW-1:0] tx_tim, next_tx_tim, half_per, next_half_per;
  logic bc, next_bc, rd_odd, next_rd_odd;
  logic next_oe, next_reg_rd;
  logic [5:0] next_reg_addr;

  // Response framing and Manchester drive
  always_comb begin
    logic [15:0] data;
    status_s st;
    logic [`MRL_RESP_PAYLOAD-1:0] pay;
    data = 16'h0000;
    st = '0;
    pay = '0;
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_left = tx_left;
    next_tx_half = tx_half;
    next_tx_tim = tx_tim;
    next_half_per = half_per;
    next_bc = bc;
    next_rd_odd = rd_odd;
    next_oe = o_link_oe;
    next_reg_rd = 1'b0;
    next_reg_addr = o_reg_addr;
    tx_load = 1'b0;
    unique case (tx_state)
      TX_IDLE: begin
        if (accept) begin
          next_reg_addr = {rx_cmd.addr[5:1], 1'b0};
          next_rd_odd = rx_cmd.addr[0];
          next_bc = (rx_cmd.target == 4'h0);
          next_reg_rd = 1'b1;
          next_half_per = period >> 1;
          next_tx_state = TX_FETCH;
        end
      end
      TX_FETCH: begin
        data = rd_odd ? {8'h00, i_reg_word[7:0]} : i_reg_word;
        st = {i_die_sel, bc, ae, ovr, cs};
        pay = {st, data};
        next_tx_shift = {2'b00, pay, crc_payload(pay)};
        next_tx_left = `MRL_RESP_LEN;
        next_tx_half = 1'b0;
        next_tx_tim = '0;
        tx_load = 1'b1;
        // drive low only, first half is inverse bit
        next_oe = 1'b0;
        next_tx_state = TX_SEND;
      end
      TX_SEND: begin
        next_tx_tim = tx_tim + 1'b1;
        if (tx_tim + 1'b1 >= half_per) begin
          next_tx_tim = '0;
          if (!tx_half) begin
            next_tx_half = 1'b1;
            next_oe = !tx_shift[26];
          end else if (tx_left == 5'h01) begin
            next_oe = 1'b0;
            next_tx_state = TX_IDLE;
          end else begin
            next_tx_half = 1'b0;
            next_tx_shift = {tx_shift[25:0], 1'b0};
            next_tx_left = tx_left - 1'b1;
            next_oe = tx_shift[25];
          end
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  // Transmitter registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_state <= TX_IDLE;
      tx_shift <= '0;
      tx_left <= '0;
      tx_half <= 1'b0;
      tx_tim <= '0;
      half_per <= '0;
      bc <= 1'b0;
      rd_odd <= 1'b0;
      o_link_oe <= 1'b0;
      o_link_out <= 1'b0;
      o_reg_rd <= 1'b0;
      o_reg_addr <= 6'h00;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_left <= next_tx_left;
      tx_half <= next_tx_half;
      tx_tim <= next_tx_tim;
      half_per <= next_half_per;
      bc <= next_bc;
      rd_odd <= next_rd_odd;
      o_link_oe <= next_oe;
      o_link_out <= 1'b0;
      o_reg_rd <= next_reg_rd;
      o_reg_addr <= next_reg_addr;
    end
  end

  // ---------------- Shadow registers ----------------
  sh_state_e sh_state, next_sh_state;
  logic [AW:0] ld_cnt, next_ld_cnt;
  logic ld_req, next_ld_req;
  logic [5:0] next_nv_addr;
  logic [AW-1:0] wr_idx, next_wr_idx;
  logic [31:0] wr_data, next_wr_data;
  logic rd_pend, next_rd_pend, rd_hit, next_rd_hit;
  logic next_busy, next_wdone, next_werr, next_rvalid;
  logic [31:0] next_rdata;
  logic mem_we;
  logic [AW-1:0] mem_waddr, mem_raddr;
  logic [63:0] mem_wdata, mem_rdata;
  logic [7:0] ext_off;
  logic ext_hit;

  assign ext_off = i_ext_req.addr - `MRL_SHADOW_OFS;
  assign ext_hit = (i_ext_req.addr >= `MRL_SHADOW_OFS) && ({1'b0, ext_off} < 9'(DEPTH));

  // Load, write and read sequencing
  always_comb begin
    next_sh_state = sh_state;
    next_ld_cnt = ld_cnt;
    next_ld_req = 1'b0;
    next_nv_addr = o_nv_addr;
    next_wr_idx = wr_idx;
    next_wr_data = wr_data;
    next_rd_pend = 1'b0;
    next_rd_hit = rd_hit;
    next_wdone = 1'b0;
    next_werr = 1'b0;
    next_rvalid = rd_pend;
    next_rdata = o_ext_rdata;
    mem_we = 1'b0;
    mem_waddr = o_nv_addr[AW-1:0];
    mem_wdata = {i_nv_word.used, i_nv_word.data & i_nv_word.used};
    mem_raddr = ext_off[AW-1:0];
    if (rd_pend) begin
      next_rdata = rd_hit ? mem_rdata[31:0] : 32'h0000_0000;
    end
    unique case (sh_state)
      SH_LOAD: begin
        mem_we = ld_req;
        if (ld_cnt < (AW+1)'(DEPTH)) begin
          next_nv_addr = 6'(ld_cnt);
          next_ld_cnt = ld_cnt + 1'b1;
          next_ld_req = 1'b1;
        end else if (!ld_req) begin
          next_sh_state = SH_READY;
        end
      end
      SH_READY: begin
        if (i_ext_wr) begin
          next_wdone = !ext_hit || i_lock_field == `MRL_LOCK_ALL;
          next_werr = next_wdone;
          if (ext_hit && i_lock_field != `MRL_LOCK_ALL) begin
            next_wr_idx = ext_off[AW-1:0];
            next_wr_data = i_ext_req.data;
            next_sh_state = SH_WRITE;
          end
        end else if (i_ext_rd) begin
          next_rd_pend = 1'b1;
          next_rd_hit = ext_hit;
        end
      end
      SH_WRITE: begin
        mem_we = 1'b1;
        mem_waddr = wr_idx;
        mem_wdata = {mem_rdata[63:32], wr_data & mem_rdata[63:32]};
        next_wdone = 1'b1;
        next_sh_state = SH_READY;
      end
      default: next_sh_state = SH_LOAD;
    endcase
    next_busy = (next_sh_state != SH_READY);
  end

  // Shadow control registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      sh_state <= SH_LOAD;
      ld_cnt <= '0;
      ld_req <= 1'b0;
      o_nv_addr <= 6'h00;
      wr_idx <= '0;
      wr_data <= 32'h0000_0000;
      rd_pend <= 1'b0;
      rd_hit <= 1'b0;
      o_ext_busy <= 1'b1;
      o_ext_wdone <= 1'b0;
      o_ext_werr <= 1'b0;
      o_ext_rvalid <= 1'b0;
      o_ext_rdata <= 32'h0000_0000;
      o_shadow_ready <= 1'b0;
    end else begin
      sh_state <= next_sh_state;
      ld_cnt <= next_ld_cnt;
      ld_req <= next_ld_req;
      o_nv_addr <= next_nv_addr;
      wr_idx <= next_wr_idx;
      wr_data <= next_wr_data;
      rd_pend <= next_rd_pend;
      rd_hit <= next_rd_hit;
      o_ext_busy <= next_busy;
      o_ext_wdone <= next_wdone;
      o_ext_werr <= next_werr;
      o_ext_rvalid <= next_rvalid;
      o_ext_rdata <= next_rdata;
      o_shadow_ready <= (next_sh_state != SH_LOAD);
    end
  end

  // Shadow storage: used mask over data
  mrl_shadow_ram #(
    .AW(AW),
    .DW(64)
  ) u_ram (
    .i_mclk(i_mclk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );
endmodule

// ### dv/mrl_link_sva.sv
`timescale 1ns/1ps
module mrl_link_sva import mrl_pkg::*; #(
  parameter int CW = 16,
  parameter int DEPTH = 64
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic o_link_out,
  input wire logic o_link_oe,
  input wire logic o_manch_on,
  input wire logic o_reg_rd,
  input wire logic [5:0] o_reg_addr,
  input wire logic o_shadow_ready,
  input wire logic [3:0] i_lock_field,
  input wire logic i_ext_wr,
  input wire logic i_ext_rd,
  input wire ext_req_s i_ext_req,
  input wire logic o_ext_busy,
  input wire logic o_ext_wdone,
  input wire logic o_ext_werr,
  input wire logic o_ext_rvalid
);
  localparam int LOAD_MAX = DEPTH + 8;
  logic in_win;

  // Shadow address window
  assign in_win = (i_ext_req.addr >= 8'h40) && (i_ext_req.addr < 8'h40 + DEPTH);

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  link_low_a:
    assert property (o_link_out == 1'b0) else $error("open-drain data not low");
  rd_mode_a:
    assert property (o_reg_rd |-> o_manch_on) else $error("fetch outside mode");
  oe_mode_a:
    assert property ($rose(o_link_oe) |-> o_manch_on) else $error("answer outside mode");
  rd_even_a:
    assert property (o_reg_rd |-> !o_reg_addr[0]) else $error("fetch address odd");
  sync_lead_a:
    assert property (o_reg_rd |-> !o_link_oe [*8]) else $error("sync first half not high");
  load_done_a:
    assert property ($fell(i_srst) |-> ##[1:LOAD_MAX] o_shadow_ready)
      else $error("shadow load too slow");
  ready_hold_a:
    assert property (o_shadow_ready |=> o_shadow_ready) else $error("shadow ready dropped");
  lock_refuse_a:
    assert property (i_ext_wr && !o_ext_busy && i_lock_field == 4'h3 |=>
      o_ext_wdone && o_ext_werr) else $error("locked write not refused");
  win_write_a:
    assert property (i_ext_wr && !o_ext_busy && i_lock_field != 4'h3 && in_win |=>
      (o_ext_busy && !o_ext_wdone) ##1 (o_ext_wdone && !o_ext_werr))
      else $error("shadow write not done");
  ext_read_a:
    assert property (i_ext_rd && !i_ext_wr && !o_ext_busy |=> !o_ext_rvalid ##1 o_ext_rvalid)
      else $error("read answer late");
endmodule

bind mrl_link mrl_link_sva #(.CW(CW), .DEPTH(DEPTH)) u_mrl_link_sva (
  .i_mclk(i_mclk), .i_srst(i_srst), .o_link_out(o_link_out), .o_link_oe(o_link_oe),
  .o_manch_on(o_manch_on), .o_reg_rd(o_reg_rd), .o_reg_addr(o_reg_addr),
  .o_shadow_ready(o_shadow_ready), .i_lock_field(i_lock_field), .i_ext_wr(i_ext_wr),
  .i_ext_rd(i_ext_rd), .i_ext_req(i_ext_req), .o_ext_busy(o_ext_busy),
  .o_ext_wdone(o_ext_wdone), .o_ext_werr(o_ext_werr), .o_ext_rvalid(o_ext_rvalid));

// ### dv/mrl_host.sv
`timescale 1ns/1ps
module mrl_host (
  input wire logic i_mclk,
  input wire logic i_link_oe,
  input wire logic i_reg_rd,
  output logic o_cmd_line
);
  logic [26:0] resp;
  logic got;
  logic halves_ok;
  int rd_at;

  // Idle line level
  initial o_cmd_line = 1'b1;

  // One frame out, optional resend during the answer, answer sampled
  task automatic xfer(input logic [31:0] frame, input int len, input int bad_at,
                      input bit ovr);
    int rel;
    int idx;
    logic first;
    logic line;
    resp = '0;
    got = 1'b0;
    halves_ok = 1'b1;
    rd_at = -1;
    first = 1'b0;
    for (int n = 0; n < len * 16 + 480; n++) begin
      @(negedge i_mclk);
      rel = (rd_at < 0) ? -1 : n - rd_at - 2;
      idx = -1;
      if (n < len * 16)
        idx = n;
      else if (ovr && rel >= 16 && rel < 16 + len * 16)
        idx = rel - 16;
      if (idx < 0 || idx / 16 == bad_at)
        o_cmd_line = 1'b1;
      else
        o_cmd_line = frame[len - 1 - idx / 16] ^ (idx % 16 < 8);
      if (rd_at < 0 && i_reg_rd === 1'b1)
        rd_at = n;
      line = !i_link_oe;
      if (rel >= 0 && rel < 432 && rel % 16 == 4)
        first = line;
      if (rel >= 0 && rel < 432 && rel % 16 == 12) begin
        resp = {resp[25:0], line};
        halves_ok = halves_ok && (first != line);
        got = 1'b1;
      end
    end
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top import mrl_pkg::*; ;
  localparam logic [31:0] USED = 32'h00FF_0FFF;
  logic mclk, srst, cmd_line, link_out, link_oe, manch_on, reg_rd, shadow_ready;
  logic ext_wr, ext_rd, ext_busy, ext_wdone, ext_werr, ext_rvalid;
  logic [1:0] die_sel;
  logic [3:0] lock_field;
  logic [5:0] reg_addr, nv_addr;
  logic [15:0] reg_word;
  logic [31:0] ext_rdata;
  nv_word_s nv_word;
  ext_req_s ext_req;
  int err_count = 0;
  int check_count = 0;
  int ks[4] = '{0, 21, 42, 63};

  always #5 mclk = ~mclk;

  // Register word and nonvolatile array answers
  assign reg_word = {reg_addr, 2'h1, 2'h2, reg_addr};
  assign nv_word = '{ecc: 7'h55, used: USED, data: {4{2'h2, nv_addr}}};

  mrl_link u_mrl_link (
    .i_mclk(mclk), .i_srst(srst), .i_cmd_line(cmd_line), .i_die_sel(die_sel),
    .o_link_out(link_out), .o_link_oe(link_oe), .o_manch_on(manch_on), .o_reg_rd(reg_rd),
    .o_reg_addr(reg_addr), .i_reg_word(reg_word), .o_nv_addr(nv_addr), .i_nv_word(nv_word),
    .o_shadow_ready(shadow_ready), .i_lock_field(lock_field), .i_ext_wr(ext_wr),
    .i_ext_rd(ext_rd), .i_ext_req(ext_req), .o_ext_busy(ext_busy), .o_ext_wdone(ext_wdone),
    .o_ext_werr(ext_werr), .o_ext_rvalid(ext_rvalid), .o_ext_rdata(ext_rdata));

  mrl_host u_mrl_host (.i_mclk(mclk), .i_link_oe(link_oe), .i_reg_rd(reg_rd),
    .o_cmd_line(cmd_line));

  // Check code, preset 111, first bit first
  function automatic logic [2:0] crc(input logic [31:0] v, input int n);
    logic [2:0] c;
    logic c0;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--) begin
      c0 = c[2] ^ v[i];
      c = {c[1], c0 ^ c[0], c0};
    end
    return c;
  endfunction

  function automatic logic [31:0] frame(input logic [26:0] p, input int n);
    return {2'b00, p, crc({5'h00, p}, n)};
  endfunction

  function automatic logic [26:0] exp_resp(input logic [1:0] die, input logic [3:0] fl,
                                           input logic [15:0] d);
    return {2'b00, die, fl, d, crc({10'h000, die, fl, d}, 22)};
  endfunction

  function automatic logic [15:0] exp_data(input logic [5:0] a);
    logic [5:0] e;
    e = {a[5:1], 1'b0};
    return a[0] ? {8'h00, 2'h2, e} : {e, 2'h1, 2'h2, e};
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Read command and full answer compare
  task automatic do_read(input logic [3:0] tid, input logic [5:0] a, input logic [26:0] exp,
                         input logic want, input int bad, input bit ovr);
    u_mrl_host.xfer(frame({16'h0000, 1'b1, tid, a}, 11), 16, bad, ovr);
    chk("response present", want, u_mrl_host.got);
    if (want) begin
      chk("response frame", exp, u_mrl_host.resp);
      chk("response halves", 1, u_mrl_host.halves_ok);
      chk("response start", 1, u_mrl_host.rd_at > 249 && u_mrl_host.rd_at < 259);
    end
  endtask

  task automatic mode(input logic [15:0] d, input logic on);
    u_mrl_host.xfer(frame({1'b0, 4'h0, 6'h3F, d}, 27), 32, -1, 0);
    chk("manchester mode", on, manch_on);
  endtask

  // Extended access with bounded wait for the answer
  task automatic ext_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] exp);
    ext_req = '{addr: a, data: d};
    ext_wr = wr;
    ext_rd = !wr;
    @(negedge mclk);
    ext_wr = 1'b0;
    ext_rd = 1'b0;
    for (int i = 0; i < 8 && ext_wdone !== 1'b1 && ext_rvalid !== 1'b1; i++)
      @(negedge mclk);
    if (ext_wdone !== 1'b1 && ext_rvalid !== 1'b1) begin
      err_count++;
      $display("mismatch ext answer expected 1 seen 0");
      conclude();
    end else begin
      chk("ext answer", exp, wr ? {31'h0, ext_werr} : ext_rdata);
    end
  endtask

  // Main sequence
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    die_sel = 2'h0;
    lock_field = 4'h0;
    ext_wr = 1'b0;
    ext_rd = 1'b0;
    ext_req = '0;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    do_read(4'h1, 6'h20, '0, 0, -1, 0);
    mode(16'h62D2, 1'b1);
    for (int d = 0; d < 4; d++) begin
      die_sel = 2'(d);
      do_read(4'(1 << d), 6'(32 + d), exp_resp(2'(d), 4'h0, exp_data(6'(32 + d))),
              1, -1, 0);
    end
    die_sel = 2'h1;
    do_read(4'h0, 6'h11, exp_resp(2'h1, 4'h8, exp_data(6'h11)), 1, -1, 0);
    do_read(4'h4, 6'h12, '0, 0, -1, 0);
    u_mrl_host.xfer(frame({16'h0000, 1'b1, 4'h2, 6'h13}, 11) ^ 32'h1, 16, -1, 0);
    chk("bad crc answer", 0, u_mrl_host.got);
    do_read(4'h2, 6'h14, exp_resp(2'h1, 4'h1, exp_data(6'h14)), 1, -1, 0);
    do_read(4'h2, 6'h15, '0, 0, 15, 0);
    do_read(4'h2, 6'h16, exp_resp(2'h1, 4'h4, exp_data(6'h16)), 1, -1, 1);
    do_read(4'h2, 6'h17, exp_resp(2'h1, 4'h2, exp_data(6'h17)), 1, -1, 0);
    do_read(4'h2, 6'h3E, exp_resp(2'h1, 4'h0, exp_data(6'h3E)), 1, -1, 0);
    mode(16'h0000, 1'b0);
    do_read(4'h2, 6'h20, '0, 0, -1, 0);
    chk("shadow ready", 1, shadow_ready);
    foreach (ks[j])
      ext_op(0, 8'(64 + ks[j]), '0, {4{2'h2, 6'(ks[j])}} & USED);
    ext_op(0, 8'h80, '0, '0);
    ext_op(1, 8'h45, 32'hFFFF_FFFF, '0);
    ext_op(0, 8'h45, '0, USED);
    ext_op(1, 8'h05, 32'h0, 32'h1);
    lock_field = 4'h3;
    ext_op(1, 8'h46, 32'hFFFF_FFFF, 32'h1);
    ext_op(0, 8'h46, '0, {4{8'h86}} & USED);
    conclude();
  end
endmodule
